// ---- common/serial_mgmt_cfg.svh ----
// Offsets, field positions, reset values and timing counts for the serial management block.
// Assumes a byte-addressed register port with 8 address bits.
`ifndef SERIAL_MGMT_CFG_SVH
`define SERIAL_MGMT_CFG_SVH

`define ADDR_W 8
`define MGMT_ACCESS_ADDR 8'h48
`define PHY_STATUS_ADDR 8'h60

`define B_XOVER_DIS 31
`define B_MULTI_FUNCTION_STRAP_STRAP 30
`define B_LED_STRAP 29
`define B_LOAD_DONE 21
`define B_RELOAD 20
`define B_MGMT_DATA_IN 19
`define B_MDIR 18
`define B_MGMT_DATA_OUT 17
`define B_MDC 16
`define B_RSVD15 15
`define B_RSVD12 12
`define B_ROM_SEL 11
`define B_RSVD10 10
`define B_ROM_DIN 3
`define B_ROM_DOUT 2
`define B_ROM_CLK 1
`define B_ROM_CS 0
`define B_INIT_CTRL 8
`define B_PHY_RESET 7

`define RSVD10_RST 1'h1
`define RSVD_9_8_VAL 2'h3
`define RSVD_7_4_VAL 4'hf
`define INIT_CTRL_RST 1'h1
`define INIT_STATUS_VAL 7'h00

`define LINK_PERIOD_NS 80
`define PHY_RST_NS 320
`define PHY_RST_CYCLES ((`PHY_RST_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)

`endif

// ---- common/serial_mgmt_pkg.sv ----
// Types shared by the serial management block.
// Constants live in serial_mgmt_cfg.svh.
package serial_mgmt_pkg;

  typedef struct packed {
    logic select;
    logic clock;
    logic dataOut;
  } rom_out_s;

  typedef struct packed {
    logic crossoverDisable;
    logic multiFunction;
    logic ledMode;
  } strap_s;

  typedef logic [6:0] phy_status_t;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_HOLD = 2'b01
  } phy_rst_e;

endpackage

// ---- src/sync_bits.sv ----
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      q <= '0;
    end else begin
      stage1_reg <= d;
      q <= stage1_reg;
    end
  end
endmodule // sync_bits

// ---- src/serial_mgmt_regs.sv ----
// Serial management access and PHY reset/status registers.
// Assumes a register port on clk and PHY status pins on the free-running linkClk.
//
// Functional notes
// - Bit 21 reads one after config load
// - Writing bit 20 reloads the config EEPROM
// - Bit 19 returns sampled management data input
// - Bit 18 one means read, pin undriven
// - Bit 17 drives management data output
// - Bit 16 drives management clock pin directly
// - Bits 31:29 show crossover and strap status
// - Bit 11 routes pins to serial EEPROM
// - Bit 3 reflects EEPROM data in pin
// - Bit 2 drives EEPROM data out pin
// - Bit 1 drives EEPROM clock pin
// - Bit 0 drives EEPROM select pin
// - Reserved bits 15, 9:8, 7:4 read ones
// - Clearing bit 8 enables functional low bits
// - Bit 7 resets PHY; one while init
// - Low bits accept only zeros during init
// - Status order: link, signal, lock, ..., 10M
`timescale 1ns/1ps
`include "serial_mgmt_cfg.svh"
module serial_mgmt_regs
  import serial_mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output rom_out_s romPins,
  input wire logic romSerialInPin,
  input wire strap_s straps,
  input wire logic configLoadDoneIn,
  output logic configReloadReq,
  input wire phy_status_t phyStatusPins,
  output logic phyResetOut
);

  // Host-side storage
  logic mdir_reg;
  logic mgmt_data_out_reg;
  logic mdc_reg;
  logic romSelMode_reg;
  logic rsvd12_reg;
  logic rsvd10_reg;
  logic reload_reg;
  logic romDout_reg;
  logic romClk_reg;
  logic romCs_reg;
  logic loadDone_reg;
  logic loadDoneSeen_reg;
  logic initCtrl_reg;
  phy_status_t initStatus_reg;
  logic rstToggle_reg;
  logic reloadReq_reg;
  rom_out_s romPins_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Link-side storage
  phy_status_t linkStatus_reg;
  logic rstToggleSeen_reg;
  phy_rst_e rstState_reg;
  logic [2:0] rstCount_reg;
  logic phyReset_reg;

  // Synchronised inputs
  logic [12:0] hostSyncIn;
  logic [12:0] hostSyncOut;
  strap_s strapSync;
  logic mdioSync;
  logic romInSync;
  logic loadDoneSync;
  phy_status_t statusSync;
  logic rstToggleSync;

  logic wrMgmt;
  logic wrStatus;
  logic rdMgmt;
  logic rdStatus;

  assign wrMgmt = wr && (addr == `MGMT_ACCESS_ADDR);
  assign wrStatus = wr && (addr == `PHY_STATUS_ADDR);
  assign rdMgmt = rd && (addr == `MGMT_ACCESS_ADDR);
  assign rdStatus = rd && (addr == `PHY_STATUS_ADDR);

  assign hostSyncIn = {straps, mdioIn, romSerialInPin, configLoadDoneIn, linkStatus_reg};
  assign {strapSync, mdioSync, romInSync, loadDoneSync, statusSync} = hostSyncOut;

  sync_bits #(.W(13)) hostSync (
    .clk(clk),
    .rst(rst),
    .d(hostSyncIn),
    .q(hostSyncOut)
  );

  sync_bits #(.W(1)) linkSync (
    .clk(linkClk),
    .rst(linkRst),
    .d(rstToggle_reg),
    .q(rstToggleSync)
  );

  // Management access register fields
  always_ff @(posedge clk) begin
    if (rst) begin
      mdir_reg <= 1'h0;
      mgmt_data_out_reg <= 1'h0;
      mdc_reg <= 1'h0;
      romSelMode_reg <= 1'h0;
      rsvd12_reg <= 1'h0;
      rsvd10_reg <= `RSVD10_RST;
      reload_reg <= 1'h0;
      romDout_reg <= 1'h0;
      romClk_reg <= 1'h0;
      romCs_reg <= 1'h0;
    end else if (wrMgmt) begin
      mdir_reg <= wdata[`B_MDIR];
      mgmt_data_out_reg <= wdata[`B_MGMT_DATA_OUT];
      mdc_reg <= wdata[`B_MDC];
      romSelMode_reg <= wdata[`B_ROM_SEL];
      rsvd12_reg <= wdata[`B_RSVD12];
      rsvd10_reg <= wdata[`B_RSVD10];
      reload_reg <= wdata[`B_RELOAD];
      romDout_reg <= wdata[`B_ROM_DOUT];
      romClk_reg <= wdata[`B_ROM_CLK];
      romCs_reg <= wdata[`B_ROM_CS];
    end
  end

  // Reload request and load-done flag; a finish edge wins over the reload clear
  always_ff @(posedge clk) begin
    if (rst) begin
      loadDone_reg <= 1'h0;
      loadDoneSeen_reg <= 1'h0;
      reloadReq_reg <= 1'h0;
    end else begin
      loadDoneSeen_reg <= loadDoneSync;
      reloadReq_reg <= wrMgmt && wdata[`B_RELOAD];
      if (loadDoneSync && !loadDoneSeen_reg) begin
        loadDone_reg <= 1'h1;
      end else if (wrMgmt && wdata[`B_RELOAD]) begin
        loadDone_reg <= 1'h0;
      end
    end
  end

  // EEPROM pins, gated by EEPROM mode
  always_ff @(posedge clk) begin
    if (rst) begin
      romPins_reg <= '0;
    end else begin
      romPins_reg.select <= romSelMode_reg && romCs_reg;
      romPins_reg.clock <= romSelMode_reg && romClk_reg;
      romPins_reg.dataOut <= romSelMode_reg && romDout_reg;
    end
  end

  // PHY reset and status register
  always_ff @(posedge clk) begin
    if (rst) begin
      initCtrl_reg <= `INIT_CTRL_RST;
      initStatus_reg <= `INIT_STATUS_VAL;
      rstToggle_reg <= 1'h0;
    end else if (wrStatus) begin
      initCtrl_reg <= wdata[`B_INIT_CTRL];
      if (initCtrl_reg) begin
        initStatus_reg <= `INIT_STATUS_VAL;
      end
      if (!initCtrl_reg && wdata[`B_PHY_RESET]) begin
        rstToggle_reg <= !rstToggle_reg;
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rdMgmt) begin
      rdata_next[`B_XOVER_DIS] = strapSync.crossoverDisable;
      rdata_next[`B_MULTI_FUNCTION_STRAP_STRAP] = strapSync.multiFunction;
      rdata_next[`B_LED_STRAP] = strapSync.ledMode;
      rdata_next[`B_LOAD_DONE] = loadDone_reg;
      rdata_next[`B_RELOAD] = reload_reg;
      rdata_next[`B_MGMT_DATA_IN] = mdioSync;
      rdata_next[`B_MDIR] = mdir_reg;
      rdata_next[`B_MGMT_DATA_OUT] = mgmt_data_out_reg;
      rdata_next[`B_MDC] = mdc_reg;
      rdata_next[`B_RSVD15] = 1'h1;
      rdata_next[`B_RSVD12] = rsvd12_reg;
      rdata_next[`B_ROM_SEL] = romSelMode_reg;
      rdata_next[`B_RSVD10] = rsvd10_reg;
      rdata_next[9:8] = `RSVD_9_8_VAL;
      rdata_next[7:4] = `RSVD_7_4_VAL;
      rdata_next[`B_ROM_DIN] = romSelMode_reg && romInSync;
      rdata_next[`B_ROM_DOUT] = romDout_reg;
      rdata_next[`B_ROM_CLK] = romClk_reg;
      rdata_next[`B_ROM_CS] = romCs_reg;
    end else if (rdStatus) begin
      rdata_next[`B_INIT_CTRL] = initCtrl_reg;
      rdata_next[`B_PHY_RESET] = initCtrl_reg;
      rdata_next[6:0] = initCtrl_reg ? initStatus_reg : statusSync;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Link domain: status capture
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkStatus_reg <= '0;
    end else begin
      linkStatus_reg <= phyStatusPins;
    end
  end

  // Link domain: PHY reset pulse stretcher
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      rstToggleSeen_reg <= 1'h0;
      rstState_reg <= RST_IDLE;
      rstCount_reg <= 3'h0;
      phyReset_reg <= 1'h0;
    end else begin
      rstToggleSeen_reg <= rstToggleSync;
      case (rstState_reg)
        RST_IDLE: begin
          if (rstToggleSync != rstToggleSeen_reg) begin
            rstState_reg <= RST_HOLD;
            rstCount_reg <= 3'(`PHY_RST_CYCLES - 1);
            phyReset_reg <= 1'h1;
          end
        end
        RST_HOLD: begin
          if (rstCount_reg == 3'h0) begin
            rstState_reg <= RST_IDLE;
            phyReset_reg <= 1'h0;
          end else begin
            rstCount_reg <= rstCount_reg - 3'h1;
          end
        end
        default: begin
          rstState_reg <= RST_IDLE;
          phyReset_reg <= 1'h0;
        end
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign mdc = mdc_reg;
  assign mdioOut = mgmt_data_out_reg;
  assign mdioOe = !mdir_reg;
  assign romPins = romPins_reg;
  assign configReloadReq = reloadReq_reg;
  assign phyResetOut = phyReset_reg;

  // Checks
  sequence s_reload_write;
    wrMgmt && wdata[`B_RELOAD];
  endsequence

  sequence s_rom_write;
    wrMgmt && wdata[`B_ROM_SEL] ##1 romSelMode_reg;
  endsequence

  a_load_done_set: assert property (@(posedge clk) disable iff (rst)
    (loadDoneSync && !loadDoneSeen_reg) |=> loadDone_reg)
    else $error("load done flag not set");

  a_reload_pulse: assert property (@(posedge clk) disable iff (rst)
    s_reload_write |=> configReloadReq ##1 !configReloadReq)
    else $error("reload request not one cycle");

  a_mgmt_data_in_read: assert property (@(posedge clk) disable iff (rst)
    rdMgmt |=> rdata[`B_MGMT_DATA_IN] == $past(mdioSync))
    else $error("mdio input not returned");

  a_mdio_dir: assert property (@(posedge clk) disable iff (rst)
    (wrMgmt && wdata[`B_MDIR]) |=> !mdioOe)
    else $error("mdio driven in read mode");

  a_mdc_follow: assert property (@(posedge clk) disable iff (rst)
    wrMgmt |=> (mdc == $past(wdata[`B_MDC])) && (mdioOut == $past(wdata[`B_MGMT_DATA_OUT])))
    else $error("management pins do not follow write");

  a_rom_select: assert property (@(posedge clk) disable iff (rst)
    s_rom_write |=> romPins.select == $past(romCs_reg))
    else $error("rom select pin wrong");

  a_rom_gated: assert property (@(posedge clk) disable iff (rst)
    (!romSelMode_reg ##1 !romSelMode_reg) |-> romPins == '0)
    else $error("rom pins active outside rom mode");

  a_reserved_ones: assert property (@(posedge clk) disable iff (rst)
    rdMgmt |=> rdata[`B_RSVD15] && (rdata[9:4] == 6'h3f))
    else $error("reserved bits not one");

  a_reset_toggle: assert property (@(posedge clk) disable iff (rst)
    (wrStatus && !initCtrl_reg && wdata[`B_PHY_RESET]) |=> rstToggle_reg != $past(rstToggle_reg))
    else $error("phy reset request lost");

  a_status_live: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && !initCtrl_reg) |=> rdata[6:0] == $past(statusSync))
    else $error("live status not returned");

  a_reset_width: assert property (@(posedge linkClk) disable iff (linkRst)
    $rose(phyResetOut) |-> phyResetOut [*4] ##1 !phyResetOut)
    else $error("phy reset width wrong");

  a_rom_clock: assert property (@(posedge clk) disable iff (rst)
    romSelMode_reg |=> romPins.clock == $past(romClk_reg))
    else $error("rom clock pin wrong");

  a_rom_data: assert property (@(posedge clk) disable iff (rst)
    romSelMode_reg |=> romPins.dataOut == $past(romDout_reg))
    else $error("rom data pin wrong");

  a_rom_din: assert property (@(posedge clk) disable iff (rst)
    (rdMgmt && romSelMode_reg) |=> rdata[`B_ROM_DIN] == $past(romInSync))
    else $error("rom input not returned");

  a_init_reads: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && initCtrl_reg) |=> rdata[8:0] == 9'h180)
    else $error("init status read wrong");

  a_strap_read: assert property (@(posedge clk) disable iff (rst)
    rdMgmt |=> rdata[31:29] == $past(strapSync))
    else $error("strap status not returned");

endmodule // serial_mgmt_regs

// ---- bench/phy_rom_model.sv ----
// Far-side model: PHY management port, serial EEPROM, config loader and PHY status pins.
// Assumes pins come from registers on clk and the PHY reset from the link domain.
`timescale 1ns/1ps
module phy_rom_model
  import serial_mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire rom_out_s romPins,
  input wire logic configReloadReq,
  input wire logic phyResetOut,
  input wire phy_status_t statusSet,
  output logic mdioIn,
  output logic romSerialInPin,
  output strap_s straps,
  output logic configLoadDoneIn,
  output phy_status_t phyStatusPins
);
  logic phyBit = 1'h1;
  logic romBit = 1'h0;
  logic [3:0] loadCnt = 4'h0;
  logic romClkSeen = 1'h0;
  assign straps = strap_s'(3'h5);
  // Wire level from the host when mdioOe is high, else from the PHY; the PHY toggles its bit on each clock rise
  assign mdioIn = mdioOe ? mdioOut : phyBit;
  always @(posedge mdc) begin
    phyBit <= ~phyBit;
  end
  // EEPROM answers with the inverse of the bit it took in
  // Clock rise is seen on clk, so data and clock may change together
  always @(posedge clk) begin
    romClkSeen <= romPins.clock;
    if (romPins.clock && !romClkSeen && romPins.select) begin
      romBit <= ~romPins.dataOut;
    end
  end
  assign romSerialInPin = romPins.select ? romBit : 1'h1;
  always @(posedge clk) begin
    if (configReloadReq) begin
      loadCnt <= 4'h8;
    end else if (loadCnt != 4'h0) begin
      loadCnt <= loadCnt - 4'h1;
    end
  end
  assign configLoadDoneIn = (loadCnt == 4'h0);
  assign phyStatusPins = phyResetOut ? 7'h00 : statusSet;
endmodule // phy_rom_model

// ---- bench/serial_mgmt_regs_tb.sv ----
// Testbench for the serial management and PHY status registers.
// Assumes the far-side model in phy_rom_model.sv.
`timescale 1ns/1ps
`include "serial_mgmt_cfg.svh"
module serial_mgmt_regs_tb
  import serial_mgmt_pkg::*;
;
  logic clk = 1'h0;
  logic linkClk = 1'h0;
  logic rst = 1'h1;
  logic linkRst = 1'h1;
  logic [`ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata;
  logic mdc, mdioIn, mdioOut, mdioOe, romSerialInPin, configLoadDoneIn, configReloadReq, phyResetOut;
  rom_out_s romPins;
  strap_s straps;
  phy_status_t phyStatusPins;
  phy_status_t statusSet = 7'h55;
  int badCount = 0;
  int samplesChecked = 0;
  int reloads = 0;
  int n;

  always #25 clk = ~clk;
  initial begin
    #13;
    forever #40 linkClk = ~linkClk;
  end

  serial_mgmt_regs dut_u (.clk(clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .romPins(romPins), .romSerialInPin(romSerialInPin), .straps(straps),
    .configLoadDoneIn(configLoadDoneIn), .configReloadReq(configReloadReq),
    .phyStatusPins(phyStatusPins), .phyResetOut(phyResetOut));

  phy_rom_model far_u (.clk(clk), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .romPins(romPins),
    .configReloadReq(configReloadReq), .phyResetOut(phyResetOut), .statusSet(statusSet),
    .mdioIn(mdioIn), .romSerialInPin(romSerialInPin), .straps(straps),
    .configLoadDoneIn(configLoadDoneIn), .phyStatusPins(phyStatusPins));

  always @(posedge clk) begin
    if (configReloadReq === 1'h1) begin
      reloads++;
    end
  end

  task automatic endSim();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // Lets synchronisers settle, then reads one word
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    repeat (4) @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask

  task automatic pinChk(input logic [5:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk({26'h0, mdc, mdioOut, mdioOe, romPins}, {26'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    endSim();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    linkRst <= 1'h0;
    rdChk(8'h48, 32'ha02087f0);
    rdChk(8'h60, 32'h00000180);
    rdChk(8'h00, 32'h00000000);
    wrReg(8'h48, 32'he02880f0);
    rdChk(8'h48, 32'ha02083f0);
    wrReg(8'h48, 32'h00030805);
    pinChk(6'h3d);
    wrReg(8'h48, 32'h00040007);
    pinChk(6'h00);
    rdChk(8'h48, 32'ha02483f7);
    wrReg(8'h48, 32'h00050007);
    rdChk(8'h48, 32'ha02d83f7);
    wrReg(8'h48, 32'h00000807);
    rdChk(8'h48, 32'ha0208bf7);
    wrReg(8'h48, 32'h00000801);
    wrReg(8'h48, 32'h00000803);
    rdChk(8'h48, 32'ha0208bfb);
    wrReg(8'h48, 32'h00100000);
    rdChk(8'h48, 32'ha01083f0);
    repeat (20) @(posedge clk);
    rdChk(8'h48, 32'ha03083f0);
    chk(32'(reloads), 32'h1);
    wrReg(8'h60, 32'h00000180);
    rdChk(8'h60, 32'h00000180);
    wrReg(8'h60, 32'h00000000);
    rdChk(8'h60, 32'h00000055);
    wrReg(8'h60, 32'h0000002a);
    rdChk(8'h60, 32'h00000055);
    wrReg(8'h60, 32'h00000080);
    n = 0;
    while (phyResetOut !== 1'h1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      badCount++;
      endSim();
    end
    n = 0;
    while (phyResetOut === 1'h1 && n < 20) begin
      @(posedge linkClk);
      #1;
      n++;
    end
    chk(32'(n), 32'h4);
    rdChk(8'h60, 32'h00000055);
    endSim();
  end
endmodule // serial_mgmt_regs_tb
